// ### hdl/hai_pkg.sv
/*
  Shared constants and types of the hardware alert interface: clock and
  carrier timing, status word layout, packet layout, mode encodings.
  Assumes one 16 MHz clock drives every file that imports it.
*/
package hai_pkg;

  // timing
  localparam int CLK_FREQ_HZ = 16_000_000;
  localparam int CARRIER_FREQ_HZ = 2_000_000;
  localparam int CARRIER_HALF_CYCLES = CLK_FREQ_HZ / (2 * CARRIER_FREQ_HZ);
  localparam int CARRIER_HALF_TOL = 1;
  localparam int QUALIFY_TIME_NS = 25_000;
  localparam int QUALIFY_CYCLES =
    (QUALIFY_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

  // status word layout, shared by flags and mask enables
  localparam int STATUS_W = 16;
  localparam int BIT_SCAN_DONE = 15;
  localparam int BIT_POR = 14;
  localparam int BIT_RESERVED = 6;
  localparam int BIT_BALANCING = 2;
  localparam int BIT_DIAG_ONE = 1;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] PACKET_RESET = 16'h0000;

  // balancing switch masking
  localparam int NUM_CELLS = 14;
  localparam int TOPCELL_W = 4;

  // mode encodings
  localparam logic HOST_IF_SPI = 1'b0;
  localparam logic DRIVE_PUSH_PULL = 1'b1;
  localparam logic [1:0] CFG_DIFFERENTIAL = 2'b10;

  typedef enum logic [1:0] {
    HAI_RX_IDLE = 2'b00,
    HAI_RX_QUALIFY = 2'b01,
    HAI_RX_DETECTED = 2'b10
  } hai_rx_state_t;

  typedef enum logic [2:0] {
    HAI_OUT_IDLE = 3'b000,
    HAI_OUT_SPI = 3'b001,
    HAI_OUT_CARRIER = 3'b010,
    HAI_OUT_DC_TEST = 3'b011,
    HAI_OUT_DIFF = 3'b100
  } hai_out_mode_t;

endpackage

// ### hdl/hai_carrier_rx.sv
/*
  Carrier qualifier for the alert input: recognises an alert only after a
  square wave at the expected frequency has lasted the qualify time.
  Assumes i_line is already synchronised to i_clock.
*/
module hai_carrier_rx #(
  parameter int HALF_CYCLES = hai_pkg::CARRIER_HALF_CYCLES,
  parameter int HALF_TOL = hai_pkg::CARRIER_HALF_TOL,
  parameter int QUALIFY = hai_pkg::QUALIFY_CYCLES
) (
  input wire logic i_clock, // 16 MHz oscillator
  input wire logic i_reset, // async, active high
  input wire logic i_enable, // receiver may listen
  input wire logic i_line, // synchronised alert input
  output logic o_detected // qualified alert present
);
  import hai_pkg::*;

  localparam int GAP_W = $clog2(HALF_CYCLES + HALF_TOL + 2);
  localparam int CNT_W = $clog2(QUALIFY + 1);
  localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(HALF_CYCLES - HALF_TOL);
  localparam logic [GAP_W-1:0] GAP_MAX = GAP_W'(HALF_CYCLES + HALF_TOL);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(QUALIFY - 1);

  initial begin
    if (HALF_CYCLES - HALF_TOL < 2 || QUALIFY < 2) begin
      $error("hai_carrier_rx: carrier or qualify count too small");
    end
  end

  logic line_d;
  logic [GAP_W-1:0] gap;
  logic [CNT_W-1:0] valid_cnt;
  hai_rx_state_t state;
  hai_rx_state_t next_state;
  logic edge_seen;
  logic half_ok;
  logic timeout;

  assign edge_seen = i_line ^ line_d;
  assign half_ok = edge_seen && (gap >= GAP_MIN) && (gap <= GAP_MAX);
  // a missing edge ends the burst; no carrier means no alert
  assign timeout = gap > GAP_MAX;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      line_d <= 1'b1; // idle level of the pulled-up line, no edge after reset
    end else begin
      line_d <= i_line;
    end
  end

  // cycles since the last edge, saturating just past the window
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      gap <= '0;
    end else if (edge_seen) begin
      gap <= GAP_W'(1);
    end else if (!timeout) begin
      gap <= gap + GAP_W'(1);
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      HAI_RX_IDLE: begin
        if (i_enable && half_ok) begin
          next_state = HAI_RX_QUALIFY;
        end
      end
      HAI_RX_QUALIFY: begin
        if (!i_enable || timeout || (edge_seen && !half_ok)) begin
          next_state = HAI_RX_IDLE;
        end else if (valid_cnt >= CNT_LAST) begin
          next_state = HAI_RX_DETECTED;
        end
      end
      HAI_RX_DETECTED: begin
        if (!i_enable || timeout || (edge_seen && !half_ok)) begin
          next_state = HAI_RX_IDLE;
        end
      end
      default: begin
        next_state = HAI_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state <= HAI_RX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      valid_cnt <= '0;
    end else if (state == HAI_RX_QUALIFY && next_state == HAI_RX_QUALIFY) begin
      valid_cnt <= valid_cnt + CNT_W'(1);
    end else begin
      valid_cnt <= '0;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_detected <= 1'b0;
    end else begin
      o_detected <= (next_state == HAI_RX_DETECTED);
    end
  end

endmodule // hai_carrier_rx

// ### hdl/hai_top.sv
/*
  Hardware alert interface: folds the masked status flags into one alert,
  drives the alert output pin in SPI, UART carrier and DC test modes,
  holds it at the UART idle level in differential mode without DC test, qualifies alerts
  from a daisy-chained neighbour and builds the alert packet status word.
  Assumes status flags and mode bits come from logic on the same clock;
  only the alert input pin is asynchronous.
*/
module hai_top #(
  parameter int CARRIER_HALF = hai_pkg::CARRIER_HALF_CYCLES,
  parameter int QUALIFY = hai_pkg::QUALIFY_CYCLES
) (
  input wire logic i_clock, // 16 MHz oscillator
  input wire logic i_reset, // async, active high
  input wire logic i_alert_iface_enable, // hardware alert interface on
  input wire logic i_host_if_select, // 0 SPI, 1 UART
  input wire logic [1:0] i_serial_port_config, // UART configuration
  input wire logic i_alert_drive_type, // SPI: 0 open-drain, 1 push-pull
  input wire logic i_idle_highz_select, // UART idle: 1 released, 0 low
  input wire logic i_alert_dc_test_enable, // UART DC test mode
  input wire logic i_user_forced_alert, // force alert without fault
  input wire logic i_scan_refresh, // one-cycle pulse at scan rate
  input wire logic [hai_pkg::STATUS_W-1:0] i_primary_status, // raw flags
  input wire logic [hai_pkg::STATUS_W-1:0] i_alert_mask_enables, // enables
  input wire logic [hai_pkg::NUM_CELLS-1:0] i_balance_switch_diag_flag, // per switch
  input wire logic [hai_pkg::TOPCELL_W-1:0] i_top_cell_select_one, // top cell
  input wire logic [hai_pkg::TOPCELL_W-1:0] i_top_cell_select_two, // top cell copy
  input wire logic i_alert_input_pin, // from neighbour, async
  output logic o_alert_output_pin, // pin output level
  output logic o_alert_output_oe, // pin driven when high
  output logic [hai_pkg::STATUS_W-1:0] o_alert_packet_status_word, // masked
  output logic [hai_pkg::STATUS_W-1:0] o_primary_status, // unmasked copy
  output logic o_alert_active, // alert currently signalled
  output logic o_neighbor_alert // qualified alert from input pin
);
  import hai_pkg::*;

  initial begin
    if (CARRIER_HALF < 2 || QUALIFY < 2) begin
      $error("hai_top: carrier half period or qualify count too small");
    end
    if (NUM_CELLS > (1 << TOPCELL_W)) begin
      $error("hai_top: top cell select cannot name every cell");
    end
    if (BIT_SCAN_DONE >= STATUS_W || BIT_POR >= STATUS_W || BIT_RESERVED >= STATUS_W) begin
      $error("hai_top: status bit position outside the word");
    end
    if (BIT_DIAG_ONE >= STATUS_W || BIT_DIAG_ONE == BIT_POR) begin
      $error("hai_top: diagnostic bit position clashes");
    end
  end

  localparam int CAR_W = $clog2(CARRIER_HALF + 1);
  localparam logic [CAR_W-1:0] CAR_LAST = CAR_W'(CARRIER_HALF - 1);

  // enabled flag set, reset flag forced through
  function automatic logic [STATUS_W-1:0] masked_flags(
    input logic [STATUS_W-1:0] flags,
    input logic [STATUS_W-1:0] enables
  );
    logic [STATUS_W-1:0] result;
    result = flags & enables;
    result[BIT_POR] = flags[BIT_POR];
    result[BIT_RESERVED] = 1'b0;
    return result;
  endfunction

  logic sync_first;
  logic sync_second;
  logic rx_enable;
  logic rx_detected;
  logic [NUM_CELLS-1:0] bal_kept;
  logic topcell_differ;
  logic [STATUS_W-1:0] status_eff;
  logic [STATUS_W-1:0] status_masked;
  logic active_cond;
  logic fault_held;
  logic alert_now;
  logic uart_mode;
  logic diff_cfg;
  logic [CAR_W-1:0] carrier_cnt;
  logic carrier_level;
  hai_out_mode_t out_mode;
  logic next_pin;
  logic next_oe;
  logic [STATUS_W-1:0] next_packet;

  assign uart_mode = (i_host_if_select != HOST_IF_SPI);
  assign diff_cfg = (i_serial_port_config == CFG_DIFFERENTIAL);

  // alert input synchroniser
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      // start at the pulled-up idle level so release makes no false edge
      sync_first <= 1'b1;
      sync_second <= 1'b1;
    end else begin
      sync_first <= i_alert_input_pin;
      sync_second <= sync_first;
    end
  end

  // receiver listens only in UART mode with the interface enabled
  assign rx_enable = i_alert_iface_enable && uart_mode;

  hai_carrier_rx #(
    .HALF_CYCLES(CARRIER_HALF),
    .HALF_TOL(CARRIER_HALF_TOL),
    .QUALIFY(QUALIFY)
  ) u_carrier_rx (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_enable(rx_enable),
    .i_line(sync_second),
    .o_detected(rx_detected)
  );

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_neighbor_alert <= 1'b0;
    end else begin
      o_neighbor_alert <= rx_detected && rx_enable;
    end
  end

  // unused switches above the top cell are hidden only when both
  // selects agree; a disagreement leaves every switch reported
  assign topcell_differ = (i_top_cell_select_one != i_top_cell_select_two);

  generate
    for (genvar g = 0; g < NUM_CELLS; g++) begin : g_bal
      localparam logic [TOPCELL_W-1:0] CELL_IDX = TOPCELL_W'(g);
      assign bal_kept[g] = i_balance_switch_diag_flag[g] &&
        (topcell_differ || (CELL_IDX < i_top_cell_select_one));
    end
  endgenerate

  // balance switch diagnostics join the first diagnostic flag
  always_comb begin
    status_eff = i_primary_status;
    status_eff[BIT_DIAG_ONE] = i_primary_status[BIT_DIAG_ONE] | (|bal_kept);
  end

  assign status_masked = masked_flags(status_eff, i_alert_mask_enables);
  assign active_cond = |status_masked;

  // readable copy keeps the unmasked flags
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_primary_status <= STATUS_RESET;
    end else begin
      o_primary_status <= i_primary_status;
    end
  end

  always_comb begin
    next_packet = status_masked;
    next_packet[BIT_SCAN_DONE] = 1'b0;
    next_packet[BIT_RESERVED] = 1'b0;
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_alert_packet_status_word <= PACKET_RESET;
    end else begin
      o_alert_packet_status_word <= next_packet;
    end
  end

  // fault state follows the scan rate so the pin does not chatter
  // between scans; a reset flag is let through at once
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      fault_held <= 1'b0;
    end else if (i_scan_refresh) begin
      fault_held <= active_cond;
    end else if (status_eff[BIT_POR]) begin
      fault_held <= 1'b1;
    end
  end

  // a qualified neighbour alert is forwarded down the chain
  assign alert_now = fault_held || i_user_forced_alert ||
    o_neighbor_alert;

  always_comb begin
    out_mode = HAI_OUT_IDLE;
    if (!uart_mode) begin
      if (i_alert_iface_enable) begin
        out_mode = HAI_OUT_SPI;
      end
    end else if (i_alert_dc_test_enable) begin
      out_mode = HAI_OUT_DC_TEST;
    end else if (!i_alert_iface_enable) begin
      out_mode = HAI_OUT_IDLE;
    end else if (diff_cfg) begin
      out_mode = HAI_OUT_DIFF;
    end else if (alert_now) begin
      out_mode = HAI_OUT_CARRIER;
    end
  end

  // carrier divider, restarted so each burst begins with a full half
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      carrier_cnt <= '0;
      carrier_level <= 1'b0;
    end else if (out_mode != HAI_OUT_CARRIER) begin
      carrier_cnt <= '0;
      carrier_level <= 1'b0;
    end else if (carrier_cnt == CAR_LAST) begin
      carrier_cnt <= '0;
      carrier_level <= ~carrier_level;
    end else begin
      carrier_cnt <= carrier_cnt + CAR_W'(1);
    end
  end

  always_comb begin
    next_pin = 1'b0;
    next_oe = 1'b0;
    case (out_mode)
      HAI_OUT_SPI: begin
        if (alert_now) begin
          next_pin = 1'b0;
          next_oe = 1'b1;
        end else begin
          next_pin = 1'b1;
          next_oe = (i_alert_drive_type == DRIVE_PUSH_PULL);
        end
      end
      HAI_OUT_CARRIER: begin
        next_pin = ~carrier_level;
        next_oe = 1'b1;
      end
      HAI_OUT_DC_TEST: begin
        next_pin = ~alert_now;
        next_oe = 1'b1;
      end
      HAI_OUT_DIFF, HAI_OUT_IDLE: begin
        if (uart_mode) begin
          next_pin = 1'b0;
          next_oe = ~i_idle_highz_select;
        end else begin
          // disabled SPI rests at its inactive level
          next_pin = 1'b1;
          next_oe = (i_alert_drive_type == DRIVE_PUSH_PULL);
        end
      end
      default: begin
        next_pin = 1'b0;
        next_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_alert_output_pin <= 1'b0;
      o_alert_output_oe <= 1'b0;
    end else begin
      o_alert_output_pin <= next_pin;
      o_alert_output_oe <= next_oe;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_alert_active <= 1'b0;
    end else begin
      // dc test only signals in UART; in SPI it changes nothing
      o_alert_active <= alert_now && (i_alert_iface_enable || (uart_mode && i_alert_dc_test_enable));
    end
  end

endmodule // hai_top

// ### dv/hai_top_props.sv
/*
  Concurrent checks on the alert interface top-level ports.
  Assumes the single clock and the async active-high reset of hai_top.
*/
module hai_top_props #(
  parameter int CARRIER_HALF = 4,
  parameter int QUALIFY = 400
) (
  input wire logic i_clock, // clock
  input wire logic i_reset, // async reset
  input wire logic i_alert_iface_enable, // enable
  input wire logic i_host_if_select, // 0 spi
  input wire logic [1:0] i_serial_port_config, // uart config
  input wire logic i_alert_drive_type, // spi drive
  input wire logic i_idle_highz_select, // uart idle
  input wire logic i_alert_dc_test_enable, // dc test
  input wire logic i_user_forced_alert, // forced alert
  input wire logic [hai_pkg::STATUS_W-1:0] i_primary_status, // flags
  input wire logic [hai_pkg::STATUS_W-1:0] i_alert_mask_enables, // enables
  input wire logic i_alert_input_pin, // neighbour line
  input wire logic o_alert_output_pin, // pin level
  input wire logic o_alert_output_oe, // pin driven
  input wire logic [hai_pkg::STATUS_W-1:0] o_alert_packet_status_word, // packet
  input wire logic [hai_pkg::STATUS_W-1:0] o_primary_status, // raw copy
  input wire logic o_alert_active, // alert out
  input wire logic o_neighbor_alert // qualified input
);
  timeunit 1ns;
  timeprecision 100ps;
  import hai_pkg::*;
  logic live;
  logic prev_in;
  int gap;
  int run;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // live masks the first edge after reset, where past inputs are stale
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      live <= 1'b0;
      prev_in <= 1'b1;
      gap <= 0;
      run <= 0;
    end else begin
      live <= 1'b1;
      prev_in <= i_alert_input_pin;
      gap <= (prev_in != i_alert_input_pin) ? 0 : gap + 1;
      run <= (gap > 6) ? 0 : run + 1;
    end
  end
  sequence carrier_high;
    (o_alert_output_pin && o_alert_output_oe) [*4];
  endsequence
  sequence carrier_low;
    (!o_alert_output_pin && o_alert_output_oe) [*4];
  endsequence
  chk_spi_alert_low:
  assert property (live && !$past(i_host_if_select) && $past(i_alert_iface_enable)
    && $past(i_user_forced_alert) |-> !o_alert_output_pin && o_alert_output_oe)
    else $error("spi alert not low");
  chk_spi_idle_level:
  assert property (live && !$past(i_host_if_select) && !o_alert_active
    |-> o_alert_output_pin && o_alert_output_oe == $past(i_alert_drive_type))
    else $error("spi idle level wrong");
  chk_uart_idle_level:
  assert property (live && $past(i_host_if_select) && !$past(i_alert_dc_test_enable)
    && !o_alert_active
    |-> !o_alert_output_pin && o_alert_output_oe == !$past(i_idle_highz_select))
    else $error("uart idle level wrong");
  chk_diff_stays_idle:
  assert property (live && $past(i_host_if_select) && !$past(i_alert_dc_test_enable)
    && $past(i_serial_port_config) == CFG_DIFFERENTIAL
    |-> !o_alert_output_pin && o_alert_output_oe == !$past(i_idle_highz_select))
    else $error("differential pin not idle");
  chk_dc_test_level:
  assert property (live && $past(i_host_if_select) && $past(i_alert_dc_test_enable)
    |-> o_alert_output_oe && o_alert_output_pin == !o_alert_active)
    else $error("dc test level wrong");
  chk_carrier_shape:
  assert property ($rose(o_alert_active) && o_alert_output_pin && $past(i_host_if_select)
    && !$past(i_alert_dc_test_enable) |-> carrier_high ##1 carrier_low)
    else $error("carrier shape wrong");
  chk_packet_mask:
  assert property (live |-> (o_alert_packet_status_word & 16'hFFFD) ==
    (($past(i_primary_status) & $past(i_alert_mask_enables) & 16'h3FBD)
    | ($past(i_primary_status) & 16'h4000)))
    else $error("packet word wrong");
  chk_status_copy:
  assert property (live |-> o_primary_status == $past(i_primary_status))
    else $error("status copy wrong");
  chk_input_ignored:
  assert property (live && (!$past(i_host_if_select) || !$past(i_alert_iface_enable))
    |-> !o_neighbor_alert)
    else $error("input alert not ignored");
  chk_qualify_time:
  assert property ($rose(o_neighbor_alert) |-> run >= QUALIFY)
    else $error("input alert too early");
endmodule // hai_top_props

bind hai_top hai_top_props #(.CARRIER_HALF(CARRIER_HALF), .QUALIFY(QUALIFY)) hai_top_props_i (
  .i_clock, .i_reset, .i_alert_iface_enable, .i_host_if_select, .i_serial_port_config,
  .i_alert_drive_type, .i_idle_highz_select, .i_alert_dc_test_enable, .i_user_forced_alert,
  .i_primary_status, .i_alert_mask_enables, .i_alert_input_pin, .o_alert_output_pin,
  .o_alert_output_oe, .o_alert_packet_status_word, .o_primary_status, .o_alert_active,
  .o_neighbor_alert);

// ### dv/hai_neighbor_model.sv
/*
  Neighbour device: sends a square-wave alert carrier on request.
  Assumes the bench clock and a pulled-up line between bursts.
*/
module hai_neighbor_model (
  input wire logic i_clock, // bench clock
  input wire logic i_send, // carrier wanted
  input wire logic [3:0] i_half, // clocks per half period
  output logic o_line // alert input pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] count;
  always @(posedge i_clock) begin
    if (!i_send) begin
      o_line <= 1'b1; // released, pull-up wins
      count <= 4'h0;
    end else if (count == i_half - 4'h1) begin
      o_line <= ~o_line;
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end
endmodule // hai_neighbor_model

// ### dv/hai_top_tb.sv
/*
  Self-checking bench of hai_top with a neighbour carrier model.
  Assumes the bound checker and a shortened qualify count.
*/
module hai_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int QUAL = 40;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic en, host, drive, idle_hz, dct, forced, refresh, send, line, pin, oe, active, nb;
  logic [1:0] cfg;
  logic [15:0] status, mask, pkt, pstat;
  logic [13:0] bal;
  logic [3:0] top1, top2, half;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int hi;

  hai_top #(.QUALIFY(QUAL)) hai_top_i (.i_clock(i_clock), .i_reset(i_reset),
    .i_alert_iface_enable(en), .i_host_if_select(host), .i_serial_port_config(cfg),
    .i_alert_drive_type(drive), .i_idle_highz_select(idle_hz),
    .i_alert_dc_test_enable(dct), .i_user_forced_alert(forced), .i_scan_refresh(refresh),
    .i_primary_status(status), .i_alert_mask_enables(mask),
    .i_balance_switch_diag_flag(bal), .i_top_cell_select_one(top1),
    .i_top_cell_select_two(top2), .i_alert_input_pin(line), .o_alert_output_pin(pin),
    .o_alert_output_oe(oe), .o_alert_packet_status_word(pkt), .o_primary_status(pstat),
    .o_alert_active(active), .o_neighbor_alert(nb));
  hai_neighbor_model hai_neighbor_model_i (.i_clock(i_clock), .i_send(send),
    .i_half(half), .o_line(line));

  always #5 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse();
    refresh = 1'b1;
    step(1);
    refresh = 1'b0;
    step(2);
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_packet();
    status = 16'hFFFF;
    step(2);
    check(pkt, 16'h4000);
    check(pstat, 16'hFFFF);
    mask = 16'hFFFF;
    status = 16'h8041;
    step(2);
    check(pkt, 16'h0001);
    status = 16'h0000;
    mask = 16'h0002;
    top1 = 4'h3;
    top2 = 4'h3;
    bal = 14'h0020;
    pulse();
    check(pkt, 16'h0000);
    bal = 14'h0004;
    step(2);
    check(pkt, 16'h0002);
    top2 = 4'h4;
    bal = 14'h0020;
    step(2);
    check(pkt, 16'h0002);
    bal = 14'h0000;
  endtask

  task automatic t_scan();
    en = 1'b1;
    drive = 1'b1;
    status = 16'h2000;
    mask = 16'h2000;
    step(3);
    check(active, 1'h0);
    pulse();
    check({pin, oe, active}, 3'h3);
    status = 16'h0000;
    step(3);
    check(active, 1'h1);
    pulse();
    check({pin, oe, active}, 3'h6);
    status = 16'h8000;
    mask = 16'h8000;
    pulse();
    check(active, 1'h1);
    mask = 16'h0000;
    pulse();
    check(active, 1'h0);
    status = 16'h4000;
    step(2);
    check(active, 1'h1);
    status = 16'h0000;
    pulse();
  endtask

  task automatic t_spi();
    drive = 1'b0;
    forced = 1'b1;
    step(2);
    check({pin, oe, active}, 3'h3);
    forced = 1'b0;
    step(2);
    check({pin, oe, active}, 3'h4);
    en = 1'b0;
    drive = 1'b1;
    forced = 1'b1;
    step(2);
    check({pin, oe, active}, 3'h6);
    dct = 1'b1;
    step(2);
    check({pin, oe, active}, 3'h6);
    dct = 1'b0;
    forced = 1'b0;
    en = 1'b1;
  endtask

  task automatic t_uart();
    host = 1'b1;
    idle_hz = 1'b1;
    step(2);
    check({pin, oe}, 2'h0);
    idle_hz = 1'b0;
    step(2);
    check({pin, oe}, 2'h1);
    forced = 1'b1;
    step(2);
    hi = 0;
    for (int k = 0; k < 16; k++) begin
      hi += int'(pin === 1'b1) + 2 * int'(oe === 1'b1);
      step(1);
    end
    check(16'(hi), 16'h28);
    cfg = 2'h2;
    step(2);
    check({pin, oe}, 2'h1);
    dct = 1'b1;
    step(2);
    check({pin, oe}, 2'h1);
    forced = 1'b0;
    step(2);
    check({pin, oe}, 2'h3);
    dct = 1'b0;
    cfg = 2'h0;
  endtask

  task automatic t_neighbor();
    half = 4'h4;
    send = 1'b1;
    step(QUAL / 2);
    send = 1'b0;
    step(10);
    check(nb, 1'h0);
    half = 4'h8;
    send = 1'b1;
    step(QUAL * 3);
    check(nb, 1'h0);
    send = 1'b0;
    step(10);
    half = 4'h4;
    send = 1'b1;
    step(QUAL + 30);
    check(nb, 1'h1);
    host = 1'b0;
    step(40);
    check(nb, 1'h0);
    send = 1'b0;
  endtask

  initial begin
    {en, host, drive, idle_hz, dct, forced, refresh, send} = '0;
    {cfg, status, mask, bal, top1, top2, half} = '0;
    step(6);
    i_reset = 1'b0;
    step(2);
    t_packet();
    t_scan();
    t_spi();
    t_uart();
    t_neighbor();
    close_out();
  end
endmodule // hai_top_tb
